// file: design/load_store_multi_sequencer.sv
`timescale 1ns/1ps

module load_store_multi_sequencer
(
    input wire logic clk,
    input wire logic rst,
    input wire lsm_pkg::cmd_t cmd,
    input wire logic privilege,
    input wire logic data_abort,
    input wire logic [lsm_pkg::DATA_W-1:0] read_data,
    input wire logic [lsm_pkg::DATA_W-1:0] store_value,
    output logic busy,
    output logic refused,
    output logic flush,
    output logic [lsm_pkg::IDX_W-1:0] store_index,
    output lsm_pkg::bus_req_t fetch_bus,
    output lsm_pkg::bus_req_t data_bus,
    output logic data_write,
    output logic data_privilege_n,
    output logic [lsm_pkg::DATA_W-1:0] write_data,
    output lsm_pkg::reg_wr_t reg_wr
);

    typedef struct packed
    {
        lsm_pkg::state_t st;
        lsm_pkg::cmd_t c;
        logic load;
        logic [lsm_pkg::REGS-1:0] left;
        logic [lsm_pkg::IDX_W-1:0] cur_idx;
        logic [lsm_pkg::IDX_W-1:0] prev_idx;
        logic prev_valid;
        logic aborted;
        logic [lsm_pkg::ADDR_W-1:0] pc_new;
        logic [1:0] refill;
        logic busy;
        logic refused;
        logic flush;
        logic [lsm_pkg::IDX_W-1:0] store_index;
        lsm_pkg::bus_req_t fbus;
        lsm_pkg::bus_req_t dbus;
        logic dwrite;
        logic dpriv_n;
        logic [lsm_pkg::DATA_W-1:0] wdata;
        lsm_pkg::reg_wr_t rw;
    } state_all_t;

    state_all_t s_q;
    state_all_t s_d;

    // Lowest set bit of a list
    function automatic logic [lsm_pkg::IDX_W-1:0] low_idx
    (
        input logic [lsm_pkg::REGS-1:0] l
    );
        logic [lsm_pkg::IDX_W-1:0] r;
        r = '0;
        for (int k = lsm_pkg::REGS - 1; k >= 0; k--)
        begin
            if (l[k])
            begin
                r = lsm_pkg::IDX_W'(k);
            end
        end
        return r;
    endfunction : low_idx

    function automatic logic [lsm_pkg::REGS-1:0] drop_low
    (
        input logic [lsm_pkg::REGS-1:0] l
    );
        return l & (l - lsm_pkg::REGS'(1));
    endfunction : drop_low

    logic [lsm_pkg::CNT_W-1:0] n_regs;
    logic [lsm_pkg::ADDR_W-1:0] pc_plus3;

    always_comb
    begin
        n_regs = '0;
        for (int k = 0; k < lsm_pkg::REGS; k++)
        begin
            n_regs = n_regs + lsm_pkg::CNT_W'(s_q.c.reg_list[k]);
        end
    end

    assign pc_plus3 = s_q.c.pc + lsm_pkg::ADDR_W'(12);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic start;
        logic pc_in;
        logic [lsm_pkg::REGS-1:0] lst;
        start = 1'b0;
        pc_in = 1'b0;
        lst = '0;
        s_d = s_q;
        s_d.refused = 1'b0;
        s_d.flush = 1'b0;
        s_d.rw = '0;
        s_d.dwrite = 1'b0;
        s_d.fbus = '{request_n: 1'b1, sequential: 1'b0, address: '0};
        s_d.dbus = '{request_n: 1'b1, sequential: 1'b0, address: '0};
        s_d.dpriv_n = privilege & ~s_q.c.user_xlat;
        // Capture word asked for in prior cycle; no writes after abort
        if (s_q.prev_valid && s_q.load && !s_q.aborted && !data_abort)
        begin
            s_d.rw.wr_en = 1'b1;
            s_d.rw.wr_index = s_q.prev_idx;
            s_d.rw.wr_data = read_data;
            if (s_q.prev_idx == lsm_pkg::PC_INDEX)
            begin
                s_d.rw.wr_en = 1'b0;
                s_d.pc_new = read_data;
            end
        end
        if (s_q.prev_valid && data_abort)
        begin
            s_d.aborted = 1'b1;
        end
        s_d.prev_valid = 1'b0;
        case (s_q.st)
            lsm_pkg::ST_IDLE:
            begin
                if (cmd.valid)
                begin
                    s_d.c = cmd;
                    s_d.aborted = 1'b0;
                    s_d.load = cmd.op == lsm_pkg::OP_MULTI_LOAD
                        || cmd.op == lsm_pkg::OP_DUAL_LOAD;
                    lst = cmd.reg_list;
                    if (cmd.op == lsm_pkg::OP_DUAL_LOAD
                        || cmd.op == lsm_pkg::OP_DUAL_STORE)
                    begin
                        // Pair Rt, Rt+1 as a two-register list
                        lst = '0;
                        lst[cmd.base_index] = 1'b1;
                        lst[cmd.base_index + lsm_pkg::IDX_W'(1)] = 1'b1;
                    end
                    s_d.c.reg_list = lst;
                    s_d.left = lst;
                    // Single store reads its register from the start
                    s_d.store_index = low_idx(lst);
                    pc_in = lst[lsm_pkg::PC_INDEX] && s_d.load;
                    if (pc_in && cmd.compressed && !cmd.is_pop)
                    begin
                        s_d.refused = 1'b1;
                    end
                    else
                    begin
                        s_d.busy = 1'b1;
                        s_d.st = (cmd.op == lsm_pkg::OP_STORE
                            && !cmd.scaled) ? lsm_pkg::ST_FIRST
                            : lsm_pkg::ST_PREP;
                    end
                end
            end
            lsm_pkg::ST_PREP:
            begin
                // Execute cycle 1: internal fetch slot
                if (s_q.c.op == lsm_pkg::OP_STORE)
                begin
                    s_d.st = lsm_pkg::ST_FIRST;
                end
                else
                begin
                    // First address N cycle from base; multi ops write base back in ST_TAIL unless a load lists it
                    s_d.dbus = '{1'b0, 1'b0, s_q.c.base};
                    s_d.dwrite = !s_q.load;
                    s_d.cur_idx = low_idx(s_q.left);
                    s_d.prev_idx = low_idx(s_q.left);
                    s_d.prev_valid = 1'b1;
                    s_d.left = drop_low(s_q.left);
                    s_d.store_index = low_idx(s_q.left);
                    s_d.st = lsm_pkg::ST_XFER;
                end
            end
            lsm_pkg::ST_FIRST:
            begin
                // Single store: N write plus S fetch
                s_d.dbus = '{1'b0, 1'b0, s_q.c.base};
                s_d.dwrite = 1'b1;
                s_d.wdata = store_value;
                s_d.fbus = '{1'b0, 1'b1, pc_plus3};
                s_d.st = lsm_pkg::ST_TAIL;
            end
            lsm_pkg::ST_XFER:
            begin
                if (!s_q.load)
                begin
                    s_d.wdata = store_value;
                end
                if (s_q.left != '0)
                begin
                    s_d.dbus = '{1'b0, 1'b1,
                        s_q.dbus.address + lsm_pkg::WORD_STEP};
                    s_d.dwrite = !s_q.load;
                    s_d.prev_idx = low_idx(s_q.left);
                    s_d.prev_valid = 1'b1;
                    s_d.store_index = low_idx(s_q.left);
                    s_d.left = drop_low(s_q.left);
                end
                pc_in = s_q.load && s_q.c.reg_list[lsm_pkg::PC_INDEX];
                // Interlock only beyond a single word
                if (drop_low(s_q.left) == '0 && !pc_in
                    && !(s_q.load && s_q.c.dep_last && n_regs > lsm_pkg::ONE)
                    && (s_q.left != '0 || s_q.c.reg_list == '0
                        || n_regs == lsm_pkg::ONE))
                begin
                    s_d.fbus = '{1'b0, 1'b1, pc_plus3};
                    s_d.st = lsm_pkg::ST_TAIL;
                end
                else if (s_q.left == '0)
                begin
                    // n+1 internal cycle
                    s_d.st = pc_in ? lsm_pkg::ST_REFILL
                        : lsm_pkg::ST_TAIL;
                    s_d.refill = '0;
                    if (!pc_in)
                    begin
                        s_d.fbus = '{1'b0, 1'b1, pc_plus3};
                    end
                end
            end
            lsm_pkg::ST_REFILL:
            begin
                if (s_q.aborted)
                begin
                    s_d.st = lsm_pkg::ST_TAIL;
                end
                else
                begin
                    s_d.flush = s_q.refill == '0;
                    s_d.fbus = '{1'b0, s_q.refill != '0, s_q.pc_new
                        + {28'h0, s_q.refill, 2'h0}};
                    s_d.refill = s_q.refill + 2'h1;
                    if (s_q.refill == lsm_pkg::REFILL_FETCHES)
                    begin
                        s_d.st = lsm_pkg::ST_TAIL;
                    end
                end
            end
            lsm_pkg::ST_TAIL:
            begin
                if (s_q.prev_valid && !s_q.load)
                begin
                    s_d.wdata = store_value;
                end
                if (s_q.prev_valid && s_q.load)
                begin
                    // Last word lands now; base update would clobber it
                    s_d.st = lsm_pkg::ST_TAIL;
                end
                else
                begin
                    // Final cycle: restore base after abort
                    if (s_q.aborted && s_q.c.op != lsm_pkg::OP_STORE)
                    begin
                        s_d.rw = '{1'b1, s_q.c.base_index,
                            s_q.c.base};
                    end
                    else if (s_q.c.op == lsm_pkg::OP_MULTI_LOAD
                        || s_q.c.op == lsm_pkg::OP_MULTI_STORE)
                    begin
                        if (!s_q.c.reg_list[s_q.c.base_index] || !s_q.load)
                        begin
                            s_d.rw = '{1'b1, s_q.c.base_index,
                                s_q.c.new_base};
                        end
                    end
                    s_d.busy = 1'b0;
                    s_d.st = lsm_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = lsm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.st <= lsm_pkg::ST_IDLE;
            s_q.dpriv_n <= 1'b0;
            s_q.fbus.request_n <= 1'b1;
            s_q.dbus.request_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign refused = s_q.refused;
    assign flush = s_q.flush;
    assign store_index = s_q.store_index;
    assign fetch_bus = s_q.fbus;
    assign data_bus = s_q.dbus;
    assign data_write = s_q.dwrite;
    assign data_privilege_n = s_q.dpriv_n;
    assign write_data = s_q.wdata;
    assign reg_wr = s_q.rw;

    ////////////////////////////////////////////////////////////////////////
    a_priv_forced: assert property (@(posedge clk) disable iff (rst)
        $past(s_q.c.user_xlat) |-> !data_privilege_n)
        else $error("privilege flag not forced low");
    a_step_four: assert property (@(posedge clk) disable iff (rst)
        !data_bus.request_n && data_bus.sequential |->
        data_bus.address == $past(data_bus.address) + 32'h4)
        else $error("sequential address not one word up");
    a_seq_follows: assert property (@(posedge clk) disable iff (rst)
        !data_bus.request_n && data_bus.sequential |->
        !$past(data_bus.request_n))
        else $error("sequential access without prior access");
    a_no_write_abort: assert property (@(posedge clk) disable iff (rst)
        s_q.aborted && s_q.st == lsm_pkg::ST_XFER |=>
        !reg_wr.wr_en)
        else $error("register written after abort");
    a_pc_not_reg: assert property (@(posedge clk) disable iff (rst)
        reg_wr.wr_en |-> reg_wr.wr_index != lsm_pkg::PC_INDEX
        || s_q.busy == 1'b0)
        else $error("pc written through register port");
    a_flush_fetch: assert property (@(posedge clk) disable iff (rst)
        flush |-> !fetch_bus.request_n && !fetch_bus.sequential
        ##1 !fetch_bus.request_n && fetch_bus.sequential)
        else $error("refetch not N then S");
    a_refuse_idle: assert property (@(posedge clk) disable iff (rst)
        refused |-> !busy)
        else $error("refused command started");
    a_store_len: assert property (@(posedge clk) disable iff (rst)
        $rose(busy) && s_q.c.op == lsm_pkg::OP_STORE |-> ##[1:3] !busy)
        else $error("store too long");
    c_flush: cover property (@(posedge clk) disable iff (rst) flush);
    c_abort: cover property (@(posedge clk) disable iff (rst) s_q.aborted);
    c_seq: cover property (@(posedge clk) disable iff (rst)
        !data_bus.request_n && data_bus.sequential);

endmodule : load_store_multi_sequencer

// file: shared/lsm_pkg.sv
package lsm_pkg;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REGS = 16;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [3:0] PC_INDEX = 4'hf;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [CNT_W-1:0] DUAL_COUNT = 5'h02;
    localparam logic [CNT_W-1:0] ONE = 5'h01;
    localparam logic [1:0] REFILL_FETCHES = 2'h2;

    // Operation codes
    typedef enum logic [2:0]
    {
        OP_STORE = 3'h0,
        OP_MULTI_LOAD = 3'h1,
        OP_MULTI_STORE = 3'h2,
        OP_DUAL_LOAD = 3'h3,
        OP_DUAL_STORE = 3'h4
    } op_t;

    // Gray-coded along the usual path
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_PREP = 3'h1,
        ST_XFER = 3'h3,
        ST_TAIL = 3'h2,
        ST_FIRST = 3'h6,
        ST_REFILL = 3'h7
    } state_t;

    typedef struct packed
    {
        logic valid;
        op_t op;
        logic [REGS-1:0] reg_list;
        logic [ADDR_W-1:0] base;
        logic [IDX_W-1:0] base_index;
        logic [ADDR_W-1:0] new_base;
        logic [ADDR_W-1:0] pc;
        logic scaled;
        logic user_xlat;
        logic compressed;
        logic is_pop;
        logic dep_last;
    } cmd_t;

    // One memory-side request
    typedef struct packed
    {
        logic request_n;
        logic sequential;
        logic [ADDR_W-1:0] address;
    } bus_req_t;

    typedef struct packed
    {
        logic wr_en;
        logic [IDX_W-1:0] wr_index;
        logic [DATA_W-1:0] wr_data;
    } reg_wr_t;

endpackage : lsm_pkg

// file: sim/mem_model.sv
`timescale 1ns/1ps

module mem_model
(
    input wire logic clk,
    input wire logic rst,
    input wire lsm_pkg::bus_req_t data_bus,
    input wire logic data_write,
    input wire logic [lsm_pkg::IDX_W-1:0] store_index,
    input wire logic abort_en,
    input wire logic [31:0] abort_addr,
    output logic data_abort,
    output logic [31:0] read_data,
    output logic [31:0] store_value
);
    // Word content is a scramble of its address, so no table is kept;
    // answers stand in the cycle the request stands, as the core samples
    always_comb
    begin
        // Idle bus shows the inverse, so stale data never looks valid
        read_data = ~(data_bus.address ^ 32'hc3a5_0f10);
        if (!data_bus.request_n && !data_write)
        begin
            read_data = data_bus.address ^ 32'hc3a5_0f10;
        end
        data_abort = !data_bus.request_n && abort_en
            && data_bus.address == abort_addr;
        store_value = {28'h7e5d_1b2, store_index};
    end
endmodule : mem_model

// file: sim/load_store_multi_sequencer_tb_top.sv
`timescale 1ns/1ps

module load_store_multi_sequencer_tb_top;
    logic clk, rst, privilege, data_abort, busy, refused, flush;
    logic data_write, data_privilege_n, abort_en, pc_done, late_wr, wr_pend;
    lsm_pkg::cmd_t cmd, cur;
    lsm_pkg::bus_req_t fetch_bus, data_bus;
    lsm_pkg::reg_wr_t reg_wr;
    logic [3:0] store_index;
    logic [31:0] read_data, store_value, write_data, abort_addr;
    logic [31:0] rf [16];
    logic [31:0] aq [$], dq [$], fq [$];
    logic [2:0] mq [$];
    logic fsq [$];
    int n_mismatch = 0, n_checks = 0, n_ref, n_flush, cyc, fa, ff;

    load_store_multi_sequencer i_dut
    (
        .clk(clk), .rst(rst), .cmd(cmd), .privilege(privilege),
        .data_abort(data_abort), .read_data(read_data),
        .store_value(store_value), .busy(busy), .refused(refused),
        .flush(flush), .store_index(store_index), .fetch_bus(fetch_bus),
        .data_bus(data_bus), .data_write(data_write),
        .data_privilege_n(data_privilege_n), .write_data(write_data),
        .reg_wr(reg_wr)
    );

    mem_model i_mem
    (
        .clk(clk), .rst(rst), .data_bus(data_bus), .data_write(data_write),
        .store_index(store_index), .abort_en(abort_en),
        .abort_addr(abort_addr), .data_abort(data_abort),
        .read_data(read_data), .store_value(store_value)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sampled mid-cycle, away from the launching edge
    always @(negedge clk)
    begin
        cyc++;
        if (wr_pend)
            dq.push_back(write_data);
        wr_pend = 1'b0;
        if (data_bus.request_n === 1'b0)
        begin
            if (fa < 0)
                fa = cyc;
            aq.push_back(data_bus.address);
            mq.push_back({data_bus.sequential, data_write, data_privilege_n});
            wr_pend = data_write;
        end
        if (fetch_bus.request_n === 1'b0)
        begin
            if (ff < 0)
                ff = cyc;
            fq.push_back(fetch_bus.address);
            fsq.push_back(fetch_bus.sequential);
        end
        if (reg_wr.wr_en === 1'b1)
        begin
            if (pc_done && reg_wr.wr_index !== cur.base_index)
                late_wr = 1'b1;
            rf[reg_wr.wr_index] = reg_wr.wr_data;
        end
        n_flush += int'(flush === 1'b1);
        n_ref += int'(refused === 1'b1);
        if (flush === 1'b1)
            pc_done = 1'b1;
    end

    task automatic finish_test();
        $display("Counts: checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    function automatic lsm_pkg::cmd_t mk(input lsm_pkg::op_t op,
        input logic [15:0] l);
        lsm_pkg::cmd_t c;
        c = '0;
        c.op = op;
        c.reg_list = l;
        c.base = {14'h0, 16'($urandom), 2'b00};
        c.new_base = c.base + 32'(4 * $countones(l));
        c.pc = {14'h0, 16'($urandom), 2'b00};
        c.user_xlat = 1'($urandom);
        c.base_index = 4'hd;
        if (op == lsm_pkg::OP_DUAL_LOAD || op == lsm_pkg::OP_DUAL_STORE)
            c.base_index = 4'(2 * $urandom_range(6));
        return c;
    endfunction : mk

    task automatic run_op(input lsm_pkg::cmd_t c, input int ab);
        int regs [$];
        int n, k, w;
        logic st, pcl, seen;
        logic [31:0] a, np;
        regs = {};
        for (k = 0; k < 16; k++)
            if (c.reg_list[k])
                regs.push_back(k);
        if (c.op == lsm_pkg::OP_DUAL_LOAD || c.op == lsm_pkg::OP_DUAL_STORE)
            regs = {int'(c.base_index), int'(c.base_index) + 1};
        n = regs.size();
        st = c.op inside {lsm_pkg::OP_STORE, lsm_pkg::OP_MULTI_STORE,
            lsm_pkg::OP_DUAL_STORE};
        pcl = c.op == lsm_pkg::OP_MULTI_LOAD && c.reg_list[15];
        abort_en = ab >= 0;
        abort_addr = c.base + 32'(4 * ab);
        for (k = 0; k < 16; k++)
            rf[k] = 32'hdead_0000 + k;
        aq = {};
        dq = {};
        fq = {};
        mq = {};
        fsq = {};
        {n_ref, n_flush, cyc, fa, ff, pc_done, late_wr} = {96'h0, -64'sd1, 2'b0};
        seen = 1'b0;
        cur = c;
        privilege = 1'($urandom);
        c.valid = 1'b1;
        cmd = c;
        @(posedge clk);
        #1;
        cmd.valid = 1'b0;
        for (w = 0; w < 300; w++)
        begin
            @(posedge clk);
            #1;
            if (busy === 1'b1)
                seen = 1'b1;
            else if (seen || w > 8)
                break;
        end
        if (w == 300)
        begin
            n_mismatch++;
            $display("Error busy expected low seen high");
            finish_test();
        end
        repeat (6) @(posedge clk);
        #1;
        $display("Done op %0d list %h abort %0d", c.op, c.reg_list, ab);
        if (c.compressed && pcl && !c.is_pop)
        begin
            chk("refused", 1, n_ref);
            chk("accesses", 0, aq.size());
            return;
        end
        chk("accesses", n, aq.size());
        for (k = 0; k < n && k < aq.size(); k++)
        begin
            a = c.base + 32'(4 * k);
            chk("address", a, aq[k]);
            chk("kind", {k > 0, st, privilege & ~c.user_xlat}, mq[k]);
            if (st && k < dq.size())
                chk("wdata", {28'h7e5d_1b2, 4'(regs[k])}, dq[k]);
            if (!st && regs[k] != 15 && (ab < 0 || k < ab))
                chk("loaded", a ^ 32'hc3a5_0f10, rf[regs[k]]);
            if (!st && ab >= 0 && k >= ab)
                chk("kept", 32'hdead_0000 + regs[k], rf[regs[k]]);
        end
        if (st)
            chk("stored", n, dq.size());
        if (c.op == lsm_pkg::OP_MULTI_LOAD || c.op == lsm_pkg::OP_MULTI_STORE)
            chk("base", ab >= 0 ? c.base : c.new_base, rf[c.base_index]);
        np = (c.base + 32'(4 * (n - 1))) ^ 32'hc3a5_0f10;
        if (pcl && ab < 0)
        begin
            chk("flush", 1, n_flush);
            chk("late write", 0, late_wr);
            chk("fetches", 3, fq.size());
            for (k = 0; k < 3 && k < fq.size(); k++)
            begin
                chk("refetch", np + 32'(4 * k), fq[k]);
                chk("refetch seq", k > 0, fsq[k]);
            end
        end
        else
        begin
            chk("fetches", 1, fq.size());
            chk("fetch", {c.pc + 32'hc, 1'b1}, {fq[0], fsq[0]});
        end
    endtask : run_op

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        lsm_pkg::cmd_t c;
        int k, g;
        rst = 1'b1;
        cmd = '0;
        privilege = 1'b0;
        abort_en = 1'b0;
        abort_addr = '0;
        wr_pend = 1'b0;
        void'($urandom(4));
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        c = mk(lsm_pkg::OP_STORE, 16'h0008);
        run_op(c, -1);
        g = fa;
        c.scaled = 1'b1;
        c.user_xlat = ~c.user_xlat;
        run_op(c, -1);
        chk("scaled delay", g + 1, fa);
        for (k = 1; k < 4; k += 2)
        begin
            c = mk(lsm_pkg::OP_MULTI_LOAD, k == 1 ? 16'h0004 : 16'h0070);
            run_op(c, -1);
            g = ff - fa;
            c.dep_last = 1'b1;
            run_op(c, -1);
            chk("interlock", g + int'(k > 1), ff - fa);
        end
        repeat (4)
        begin
            run_op(mk(lsm_pkg::OP_MULTI_LOAD,
                16'($urandom) & 16'h1fff | 16'h1), -1);
            run_op(mk(lsm_pkg::OP_MULTI_LOAD,
                16'($urandom) & 16'h1fff | 16'h8000), -1);
            run_op(mk(lsm_pkg::OP_MULTI_STORE,
                16'($urandom) & 16'h1fff | 16'h2), -1);
        end
        run_op(mk(lsm_pkg::OP_MULTI_LOAD, 16'h8000), -1);
        run_op(mk(lsm_pkg::OP_MULTI_STORE, 16'h0001), -1);
        run_op(mk(lsm_pkg::OP_MULTI_LOAD, 16'h00f0), 2);
        run_op(mk(lsm_pkg::OP_MULTI_STORE, 16'h0f00), 1);
        run_op(mk(lsm_pkg::OP_DUAL_LOAD, 16'h0), -1);
        run_op(mk(lsm_pkg::OP_DUAL_STORE, 16'h0), -1);
        c = mk(lsm_pkg::OP_MULTI_LOAD, 16'h8003);
        c.compressed = 1'b1;
        run_op(c, -1);
        c.is_pop = 1'b1;
        run_op(c, -1);
        finish_test();
    end
endmodule : load_store_multi_sequencer_tb_top
